// >>> core/dcd_pkg.sv
`default_nettype none
package dcd_pkg;
   // register addresses on the special-function-register bus
   localparam logic [7:0] ADDR_CH0_LOW = 8'h96;
   localparam logic [7:0] ADDR_CH0_HIGH = 8'h97;
   localparam logic [7:0] ADDR_CH1_CTRL = 8'hB5;
   localparam logic [7:0] ADDR_CH0_CTRL = 8'hB9;
   localparam logic [7:0] ADDR_CH1_LOW = 8'hF4;
   localparam logic [7:0] ADDR_CH1_HIGH = 8'hF5;

   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h73;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [11:0] CODE_RESET = 12'h000;
   localparam logic [7:0] READ_IDLE = 8'h00;

   // control field positions
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_SRC_HI = 6;
   localparam int CTRL_SRC_LO = 4;
   localparam int CTRL_RSVD_BIT = 3;
   localparam int CTRL_RJ_BIT = 2;
   localparam int CTRL_FS_HI = 1;
   localparam int CTRL_FS_LO = 0;

   // update source codes
   localparam logic [2:0] SRC_TIMER0 = 3'h0;
   localparam logic [2:0] SRC_TIMER1 = 3'h1;
   localparam logic [2:0] SRC_TIMER2 = 3'h2;
   localparam logic [2:0] SRC_TIMER3 = 3'h3;
   localparam logic [2:0] SRC_RISE = 3'h4;
   localparam logic [2:0] SRC_FALL = 3'h5;
   localparam logic [2:0] SRC_ANY = 3'h6;
   localparam logic [2:0] SRC_ON_DEMAND = 3'h7;

   // full-scale current codes
   localparam logic [1:0] FS_0MA25 = 2'h0;
   localparam logic [1:0] FS_0MA5 = 2'h1;
   localparam logic [1:0] FS_1MA = 2'h2;
   localparam logic [1:0] FS_2MA = 2'h3;

   localparam int NUM_CHAN = 2;
   localparam int NUM_EVENTS = 8;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;
endpackage
`default_nettype wire

// >>> core/dcd_channel.sv
`default_nettype none
module dcd_channel #(
   parameter logic RJST_WRITABLE = 1'b0
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ctrl_wr,
   input wire logic low_wr,
   input wire logic high_wr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] update_events,
   output logic [7:0] ctrl_q,
   output logic [7:0] low_q,
   output logic [7:0] high_q,
   output logic [11:0] code_q
);
   logic [7:0] ctrl_d;
   logic [7:0] low_d;
   logic [7:0] high_d;
   logic [11:0] code_d;
   logic rj;
   logic [2:0] src;
   logic fire;
   logic rj_next;
   logic [11:0] word_now;

   // assemble the 12-bit word from the two bytes
   function automatic logic [11:0] justify(input logic right,
         input logic [7:0] hi, input logic [7:0] lo);
      if (right) begin
         justify = {hi[3:0], lo}; // RULE_02
      end else begin
         justify = {hi, lo[7:4]}; // RULE_01
      end
   endfunction

   assign rj = ctrl_q[dcd_pkg::CTRL_RJ_BIT];
   assign src = ctrl_q[dcd_pkg::CTRL_SRC_HI:dcd_pkg::CTRL_SRC_LO];
   // justification is fixed unless the part is built with it writable
   assign rj_next = RJST_WRITABLE ? wdata[dcd_pkg::CTRL_RJ_BIT] : rj; // RULE_03

   // reserved bit always stored as zero
   assign ctrl_d = ctrl_wr ? {wdata[7:4], 1'b0, rj_next, wdata[1:0]}
                           : ctrl_q; // RULE_09
   // unused nibble forced to zero on write, so reads show 0000b
   assign high_d = !high_wr ? high_q
                  : rj ? {dcd_pkg::NIBBLE_ZERO, wdata[3:0]}
                  : wdata; // RULE_10
   assign low_d = !low_wr ? low_q
                 : rj ? wdata
                 : {wdata[7:4], dcd_pkg::NIBBLE_ZERO}; // RULE_10

   assign fire = update_events[src]; // RULE_06 RULE_07 RULE_08
   // on demand the new high byte joins the held low byte in one step
   assign word_now = (src == dcd_pkg::SRC_ON_DEMAND)
                    ? justify(rj, high_d, low_q)
                    : justify(rj, high_q, low_q); // RULE_16 RULE_17
   // latch holds across enable changes until an update
   assign code_d = fire ? word_now : code_q; // RULE_20

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ctrl_q <= dcd_pkg::CTRL_RESET; // RULE_04 RULE_05
         low_q <= dcd_pkg::DATA_RESET;
         high_q <= dcd_pkg::DATA_RESET;
         code_q <= dcd_pkg::CODE_RESET; // RULE_20
      end else begin
         ctrl_q <= ctrl_d;
         low_q <= low_d;
         high_q <= high_d;
         code_q <= code_d;
      end
   end
endmodule
`default_nettype wire

// >>> core/dcd_update_control.sv
// How it works
// RULE_01 - left justify: high byte, low upper nibble
// RULE_02 - right justify: high lower nibble, low byte
// RULE_03 - control bit 2 selects justification, reset 0
// RULE_04 - control bits 1..0 choose full-scale current
// RULE_05 - control bit 7 enables channel, reset off
// RULE_06 - sources 000..011 update on timer overflows
// RULE_07 - sources 100..110 update on strobe edges
// RULE_08 - source 111 updates on high-byte write
// RULE_09 - reserved control bit 3 reads zero
// RULE_10 - unused data nibble reads as zero
// RULE_11 - channel 0 on pin 0; channel 1 by merge
// RULE_12 - both disabled: pins stay general purpose
// RULE_13 - enabled channel takes pin, driver off
// RULE_14 - both enabled and merged share pin 0
// RULE_15 - software sets crossbar skip for used pins
// RULE_16 - on demand, low write waits for high
// RULE_17 - timer or edge modes copy on event
// RULE_18 - timers 2/3 use low or high overflow
// RULE_19 - software writes low byte before high
// RULE_20 - converter latch resets zero, holds until update
`default_nettype none
module dcd_update_control #(
   parameter logic RJST_WRITABLE = 1'b0
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   input wire logic [1:0] timer01_overflow,
   input wire logic [1:0] timer23_low_overflow,
   input wire logic [1:0] timer23_high_overflow,
   input wire logic [1:0] timer23_split8,
   input wire logic conversion_start_strobe,
   input wire logic output_merge_select,
   output logic [11:0] chan0_code,
   output logic [11:0] chan1_code,
   output logic [1:0] chan0_full_scale_sel,
   output logic [1:0] chan1_full_scale_sel,
   output logic chan0_enable,
   output logic chan1_enable,
   output logic pin0_analog_connect,
   output logic pin1_analog_connect,
   output logic pin0_digital_disable,
   output logic pin1_digital_disable,
   output logic chan1_on_pin0,
   output logic pins_merged
);
   // per-channel register images
   logic [7:0] ctrl_q [dcd_pkg::NUM_CHAN];
   logic [7:0] low_q [dcd_pkg::NUM_CHAN];
   logic [7:0] high_q [dcd_pkg::NUM_CHAN];
   logic [11:0] code_q [dcd_pkg::NUM_CHAN];
   logic [7:0] events [dcd_pkg::NUM_CHAN];
   logic [dcd_pkg::NUM_CHAN-1:0] ctrl_wr;
   logic [dcd_pkg::NUM_CHAN-1:0] low_wr;
   logic [dcd_pkg::NUM_CHAN-1:0] high_wr;

   // strobe synchroniser and edge history
   logic strobe_meta_q;
   logic strobe_sync_q;
   logic strobe_prev_q;
   logic strobe_rise;
   logic strobe_fall;
   logic strobe_any;

   // timer event selection
   logic timer2_event;
   logic timer3_event;

   // register read path
   logic [7:0] rdata_d;
   logic [7:0] sfr_rdata_q;

   // pin routing state
   logic en0;
   logic en1;
   logic merge;
   logic pin0_connect_d;
   logic pin1_connect_d;
   logic chan1_on_pin0_d;
   logic merged_d;
   logic pin0_connect_q;
   logic pin1_connect_q;
   logic pin0_disable_q;
   logic pin1_disable_q;
   logic chan1_on_pin0_q;
   logic merged_q;

   // address match, shared by the write strobes and the read mux
   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      hit = (a == b);
   endfunction

   // write strobes, one per register
   assign ctrl_wr[0] = sfr_wr && hit(sfr_addr, dcd_pkg::ADDR_CH0_CTRL);
   assign ctrl_wr[1] = sfr_wr && hit(sfr_addr, dcd_pkg::ADDR_CH1_CTRL);
   assign low_wr[0] = sfr_wr && hit(sfr_addr, dcd_pkg::ADDR_CH0_LOW);
   assign low_wr[1] = sfr_wr && hit(sfr_addr, dcd_pkg::ADDR_CH1_LOW);
   assign high_wr[0] = sfr_wr && hit(sfr_addr, dcd_pkg::ADDR_CH0_HIGH);
   assign high_wr[1] = sfr_wr && hit(sfr_addr, dcd_pkg::ADDR_CH1_HIGH);

   // the strobe pin is asynchronous; only the second stage is looked at
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         strobe_meta_q <= 1'b0;
         strobe_sync_q <= 1'b0;
         strobe_prev_q <= 1'b0;
      end else begin
         strobe_meta_q <= conversion_start_strobe;
         strobe_sync_q <= strobe_meta_q;
         strobe_prev_q <= strobe_sync_q;
      end
   end

   // edges seen two to three cycles after the pin moves
   assign strobe_rise = strobe_sync_q && !strobe_prev_q;
   assign strobe_fall = !strobe_sync_q && strobe_prev_q;
   assign strobe_any = strobe_rise || strobe_fall;

   // timers 2 and 3 report low-byte overflow when split into 8-bit halves
   assign timer2_event = timer23_split8[0] ? timer23_low_overflow[0]
                                           : timer23_high_overflow[0]; // RULE_18
   assign timer3_event = timer23_split8[1] ? timer23_low_overflow[1]
                                           : timer23_high_overflow[1]; // RULE_18

   // one event bank per channel, indexed by the update source code
   genvar ch;
   generate
      for (ch = 0; ch < dcd_pkg::NUM_CHAN; ch++) begin : g_chan
         assign events[ch][dcd_pkg::SRC_TIMER0] = timer01_overflow[0]; // RULE_06
         assign events[ch][dcd_pkg::SRC_TIMER1] = timer01_overflow[1];
         assign events[ch][dcd_pkg::SRC_TIMER2] = timer2_event;
         assign events[ch][dcd_pkg::SRC_TIMER3] = timer3_event;
         assign events[ch][dcd_pkg::SRC_RISE] = strobe_rise; // RULE_07
         assign events[ch][dcd_pkg::SRC_FALL] = strobe_fall;
         assign events[ch][dcd_pkg::SRC_ANY] = strobe_any;
         // the channel's own high-byte write is its on-demand event
         assign events[ch][dcd_pkg::SRC_ON_DEMAND] = high_wr[ch]; // RULE_08

         dcd_channel #(
            .RJST_WRITABLE(RJST_WRITABLE)
         ) u_chan (
            .clk_sys(clk_sys),
            .reset(reset),
            .ctrl_wr(ctrl_wr[ch]),
            .low_wr(low_wr[ch]),
            .high_wr(high_wr[ch]),
            .wdata(sfr_wdata),
            .update_events(events[ch]),
            .ctrl_q(ctrl_q[ch]),
            .low_q(low_q[ch]),
            .high_q(high_q[ch]),
            .code_q(code_q[ch])
         );
      end
   endgenerate

   // read mux; unmapped addresses and idle cycles return zero
   assign rdata_d =
      !sfr_rd ? dcd_pkg::READ_IDLE
      : hit(sfr_addr, dcd_pkg::ADDR_CH0_CTRL) ? ctrl_q[0] // RULE_09
      : hit(sfr_addr, dcd_pkg::ADDR_CH1_CTRL) ? ctrl_q[1]
      : hit(sfr_addr, dcd_pkg::ADDR_CH0_LOW) ? low_q[0]
      : hit(sfr_addr, dcd_pkg::ADDR_CH1_LOW) ? low_q[1]
      : hit(sfr_addr, dcd_pkg::ADDR_CH0_HIGH) ? high_q[0]
      : hit(sfr_addr, dcd_pkg::ADDR_CH1_HIGH) ? high_q[1]
      : dcd_pkg::READ_IDLE;

   // read data registered so the port comes from a flop
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sfr_rdata_q <= dcd_pkg::READ_IDLE;
      end else begin
         sfr_rdata_q <= rdata_d;
      end
   end

   // enables and merge select feeding the pin routing
   assign en0 = ctrl_q[0][dcd_pkg::CTRL_EN_BIT]; // RULE_05
   assign en1 = ctrl_q[1][dcd_pkg::CTRL_EN_BIT];
   assign merge = output_merge_select;

   // pin 0 carries channel 0 while it is enabled; channel 1 joins it when merged
   assign pin0_connect_d = en0 || (en1 && merge); // RULE_11 RULE_13
   assign pin1_connect_d = en1 && !merge; // RULE_11 RULE_13
   assign chan1_on_pin0_d = en1 && merge; // RULE_11
   assign merged_d = en0 && en1 && merge; // RULE_14

   // pin control is one cycle behind the enables; harmless for an
   // analog switch and keeps every pin signal glitch free
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pin0_connect_q <= 1'b0; // RULE_12
         pin1_connect_q <= 1'b0;
         pin0_disable_q <= 1'b0;
         pin1_disable_q <= 1'b0;
         chan1_on_pin0_q <= 1'b0;
         merged_q <= 1'b0;
      end else begin
         pin0_connect_q <= pin0_connect_d;
         pin1_connect_q <= pin1_connect_d;
         // driver and weak pull-up off exactly while the pin is taken
         pin0_disable_q <= pin0_connect_d; // RULE_13
         pin1_disable_q <= pin1_connect_d; // RULE_13
         chan1_on_pin0_q <= chan1_on_pin0_d;
         merged_q <= merged_d;
      end
   end

   // outputs, every one straight from a flop
   assign sfr_rdata = sfr_rdata_q;
   assign chan0_code = code_q[0];
   assign chan1_code = code_q[1];
   assign chan0_full_scale_sel =
      ctrl_q[0][dcd_pkg::CTRL_FS_HI:dcd_pkg::CTRL_FS_LO]; // RULE_04
   assign chan1_full_scale_sel =
      ctrl_q[1][dcd_pkg::CTRL_FS_HI:dcd_pkg::CTRL_FS_LO]; // RULE_04
   assign chan0_enable = en0;
   assign chan1_enable = en1;
   assign pin0_analog_connect = pin0_connect_q;
   assign pin1_analog_connect = pin1_connect_q;
   assign pin0_digital_disable = pin0_disable_q;
   assign pin1_digital_disable = pin1_disable_q;
   assign chan1_on_pin0 = chan1_on_pin0_q;
   assign pins_merged = merged_q;
endmodule
`default_nettype wire

// >>> testbench/dcd_update_checker.sv
`default_nettype none
module dcd_update_checker (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic [1:0] timer01_overflow,
   input wire logic [1:0] timer23_low_overflow,
   input wire logic [1:0] timer23_high_overflow,
   input wire logic conversion_start_strobe,
   input wire logic output_merge_select,
   input wire logic [11:0] chan0_code,
   input wire logic chan0_enable,
   input wire logic chan1_enable,
   input wire logic pin0_analog_connect,
   input wire logic pin1_analog_connect,
   input wire logic pin0_digital_disable,
   input wire logic pin1_digital_disable,
   input wire logic chan1_on_pin0,
   input wire logic pins_merged
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // every source that may legally move a code, except the strobe
   wire logic tick = sfr_wr | (|timer01_overflow)
      | (|timer23_low_overflow) | (|timer23_high_overflow);
   wire logic ctrl_rd = sfr_rd & (sfr_addr == dcd_pkg::ADDR_CH0_CTRL
      | sfr_addr == dcd_pkg::ADDR_CH1_CTRL);
   // strobe needs sync stages, so look back a few edges
   sequence s_cause;
      $past(tick) || $past(tick, 2)
      || $past(conversion_start_strobe, 2) != $past(conversion_start_strobe, 3)
      || $past(conversion_start_strobe, 3) != $past(conversion_start_strobe, 4)
      || $past(conversion_start_strobe, 1) != $past(conversion_start_strobe, 2);
   endsequence
   sequence s_pin0_up;
      ##1 pin0_analog_connect && pin0_digital_disable;
   endsequence
   a_driver_off: assert property (
      pin0_digital_disable == pin0_analog_connect
      && pin1_digital_disable == pin1_analog_connect)
      else $error("driver disable differs from connect");
   a_pin0_map: assert property (
      pin0_analog_connect == $past(chan0_enable
      || chan1_enable && output_merge_select))
      else $error("pin0 connect wrong");
   a_pin1_map: assert property (
      pin1_analog_connect == $past(chan1_enable && !output_merge_select)
      && chan1_on_pin0 == $past(chan1_enable && output_merge_select))
      else $error("pin1 or channel1 route wrong");
   a_merge_both: assert property (
      pins_merged == $past(chan0_enable && chan1_enable
      && output_merge_select))
      else $error("merge flag wrong");
   a_idle_gpio: assert property (
      !$past(chan0_enable || chan1_enable)
      |-> !pin0_analog_connect && !pin1_analog_connect)
      else $error("pin taken while disabled");
   a_rsvd_zero: assert property (
      $past(ctrl_rd) |-> !sfr_rdata[dcd_pkg::CTRL_RSVD_BIT])
      else $error("reserved bit read as one");
   a_code_cause: assert property (
      $changed(chan0_code) |-> s_cause)
      else $error("code moved without an event");
   a_enable_pin: assert property (
      $rose(chan0_enable) |-> s_pin0_up)
      else $error("enabled channel did not take pin");
endmodule
bind dcd_update_control dcd_update_checker chk_u (.clk_sys(clk_sys),
   .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_rdata(sfr_rdata), .timer01_overflow(timer01_overflow),
   .timer23_low_overflow(timer23_low_overflow),
   .timer23_high_overflow(timer23_high_overflow),
   .conversion_start_strobe(conversion_start_strobe),
   .output_merge_select(output_merge_select), .chan0_code(chan0_code),
   .chan0_enable(chan0_enable), .chan1_enable(chan1_enable),
   .pin0_analog_connect(pin0_analog_connect),
   .pin1_analog_connect(pin1_analog_connect),
   .pin0_digital_disable(pin0_digital_disable),
   .pin1_digital_disable(pin1_digital_disable),
   .chan1_on_pin0(chan1_on_pin0), .pins_merged(pins_merged));
`default_nettype wire

// >>> testbench/dcd_update_control_tb.sv
`default_nettype none
module dcd_update_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, reset = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
   logic [1:0] t01 = 2'h0, t23l = 2'h0, t23h = 2'h0, split8 = 2'h0;
   logic strobe = 1'b0, merge = 1'b0;
   logic [11:0] code0, code1, exp0;
   logic [1:0] fs0, fs1;
   logic en0, en1, p0, p1, d0, d1, c1p0, mrg;
   int bad_count = 0, checks_done = 0;
   always #12.5 clk_sys = ~clk_sys;
   // right justify made writable so both layouts can be exercised
   dcd_update_control #(.RJST_WRITABLE(1'b1)) dut_u (.clk_sys(clk_sys),
      .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .timer01_overflow(t01), .timer23_low_overflow(t23l),
      .timer23_high_overflow(t23h), .timer23_split8(split8),
      .conversion_start_strobe(strobe), .output_merge_select(merge),
      .chan0_code(code0), .chan1_code(code1), .chan0_full_scale_sel(fs0),
      .chan1_full_scale_sel(fs1), .chan0_enable(en0), .chan1_enable(en1),
      .pin0_analog_connect(p0), .pin1_analog_connect(p1),
      .pin0_digital_disable(d0), .pin1_digital_disable(d1),
      .chan1_on_pin0(c1p0), .pins_merged(mrg));
   task automatic cmp(input logic [11:0] got, exp, input string what);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // one-cycle strobe, then one spare cycle so registered results land
   task automatic wr(input logic [7:0] a, d);
      @(negedge clk_sys);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk_sys);
      sfr_wr = 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, e);
      @(negedge clk_sys);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk_sys);
      sfr_rd = 1'b0;
      cmp({4'h0, sfr_rdata}, {4'h0, e}, "read");
   endtask
   task automatic fire(input int ev);
      @(negedge clk_sys);
      case (ev)
         0: t01 = 2'b01;
         1: t01 = 2'b10;
         2: t23l = 2'b01;
         3: t23h = 2'b01;
         4: t23l = 2'b10;
         5: t23h = 2'b10;
         default: strobe = ~strobe;
      endcase
      @(negedge clk_sys);
      t01 = 2'h0;
      t23l = 2'h0;
      t23h = 2'h0;
      repeat (4) @(negedge clk_sys);
   endtask
   task automatic t_reset;
      rd(8'hB9, 8'h73);
      rd(8'hB5, 8'h73);
      rd(8'h96, 8'h00);
      rd(8'hF5, 8'h00);
      rd(8'hB6, 8'h00);
      cmp(code0 | code1, 12'h000, "code");
      cmp(fs0 & fs1, 2'h3, "scale");
      cmp(en0 | en1 | p0 | p1 | d0 | d1, 1'b0, "idle");
   endtask
   task automatic t_on_demand;
      logic [7:0] lo [2] = '{8'h96, 8'hF4};
      for (int c = 0; c < 2; c++) begin
         wr(lo[c], 8'h3F);
         cmp(c ? code1 : code0, 12'h000, "held");
         rd(lo[c], 8'h30);
         wr(lo[c] + 8'h01, 8'hAB);
         cmp(c ? code1 : code0, 12'hAB3, "demand");
      end
   endtask
   task automatic t_right;
      wr(8'hB5, 8'h7E);
      rd(8'hB5, 8'h76);
      cmp(fs1, 2'h2, "scale");
      wr(8'hF4, 8'hCD);
      wr(8'hF5, 8'hFA);
      rd(8'hF5, 8'h0A);
      cmp(code1, 12'hACD, "right");
      wr(8'hB5, 8'h73);
   endtask
   // timer 2 in 8-bit mode, timer 3 in 16-bit mode
   task automatic t_sources;
      int wrong [7] = '{1, 0, 3, 4, 0, 0, 0};
      int right [7] = '{0, 1, 2, 5, 6, 6, 6};
      split8 = 2'b01;
      exp0 = 12'hAB3;
      for (int m = 0; m < 7; m++) begin
         wr(8'hB9, {1'b0, m[2:0], 2'b00, m[1:0]});
         cmp(fs0, m[1:0], "scale");
         wr(8'h96, 8'h50);
         wr(8'h97, 8'h10 + m[7:0]);
         cmp(code0, exp0, "held");
         fire(wrong[m]);
         cmp(code0, exp0, "other");
         fire(right[m]);
         exp0 = {8'h10 + m[7:0], 4'h5};
         cmp(code0, exp0, "event");
      end
   endtask
   // crossbar lies outside; pins under test count as skipped
   task automatic t_pins;
      logic e0, e1, m;
      for (int k = 0; k < 8; k++) begin
         {e0, e1, m} = k[2:0];
         @(negedge clk_sys);
         merge = m;
         wr(8'hB9, {e0, 7'h73});
         wr(8'hB5, {e1, 7'h73});
         cmp({en0, en1}, {e0, e1}, "enable");
         cmp(p0, e0 | e1 & m, "pin0");
         cmp({p1, c1p0}, {e1 & ~m, e1 & m}, "pin1");
         cmp({d0, d1}, {e0 | e1 & m, e1 & ~m}, "driver");
         cmp(mrg, e0 & e1 & m, "merge");
         cmp(code0, exp0, "keep");
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      @(negedge clk_sys);
      reset = 1'b0;
      t_reset();
      $display("reset test done");
      t_on_demand();
      $display("on demand test done");
      t_right();
      $display("right justify test done");
      t_sources();
      $display("update source test done");
      t_pins();
      $display("pin test done");
      report_and_stop();
   end
   // whole run needs well under a thousand cycles
   initial begin
      #500us;
      bad_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      report_and_stop();
   end
endmodule
`default_nettype wire
